// ==== hw/pph_pkg.sv ====
// Shared constants and carriers for the parallel port handshake block.
// Assumes a single 100 MHz clock domain.
package pph_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;

  // Protocol selection
  typedef enum logic [1:0]
  {
    PPH_MODE_FIFO  = 2'h0,
    PPH_MODE_ECP   = 2'h1,
    PPH_MODE_EPP19 = 2'h2,
    PPH_MODE_EPP17 = 2'h3
  } pph_mode_t;

  // Timing figures in ns and derived cycle counts
  localparam int unsigned WAIT_QUIET_NS    = 50;
  localparam int unsigned BUSY_QUAL_NS     = 75;
  localparam int unsigned CMD_DELAY_MIN_NS = 60;
  localparam int unsigned CMD_DELAY_MAX_NS = 210;
  localparam int unsigned HIZ_MAX_NS       = 180;
  localparam int unsigned DATA_HOLD_NS     = 50;
  localparam int unsigned FIFO_SETUP_NS    = 600;
  localparam int unsigned FIFO_PULSE_NS    = 600;
  localparam int unsigned FIFO_HOLD_NS     = 450;
  localparam int unsigned FIFO_BUSY_GAP_NS = 680;

  localparam int unsigned WAIT_QUIET_CYC = (WAIT_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned BUSY_QUAL_CYC  = (BUSY_QUAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CMD_DELAY_CYC  = (CMD_DELAY_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CMD_LATEST_CYC = CMD_DELAY_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned HIZ_CYC        = CMD_DELAY_CYC;
  localparam int unsigned DATA_HOLD_CYC  = (DATA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_SETUP_CYC = (FIFO_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_PULSE_CYC = (FIFO_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_HOLD_CYC  = (FIFO_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned FIFO_GAP_CYC   = (FIFO_BUSY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int unsigned TMR_W = 8;
  localparam int unsigned FLT_W = 4;

  localparam int unsigned DATA_W     = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Reset values of cable outputs
  localparam logic [7:0] DATA_RESET = 8'h00;

  // Cable side signals
  typedef struct packed
  {
    logic       strobe_n;
    logic       autofd_n;
    logic       write_n;
    logic       addr_strobe_n;
    logic [7:0] data_out;
    logic       data_oe;
  } pph_cable_out_t;

  typedef struct packed
  {
    logic       busy;
    logic       ack_n;
    logic       fault_n;
    logic       wait_n;
    logic [7:0] data_in;
  } pph_cable_in_t;

  // Host side EPP command
  typedef struct packed
  {
    logic       is_read;
    logic       is_addr;
    logic [7:0] wdata;
  } pph_epp_cmd_t;

endpackage

// ==== hw/pph_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; clock enable freezes all state.
`timescale 1ns/1ps
module pph_fifo
  import pph_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
)
(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);

  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed
  {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } pph_fifo_state_t;

  pph_fifo_state_t  st;
  pph_fifo_state_t  next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = mem[st.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
    end
    if (pop)
    begin
      next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
    end
    if (push && !pop)
    begin
      next_st.count = st.count + 1'b1;
    end
    else if (pop && !push)
    begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  // Storage has no reset
  always_ff @(posedge clock)
  begin
    if (clk_en && push)
    begin
      mem[st.wr_ptr] <= in_data;
    end
  end

endmodule

// ==== hw/pph_top.sv ====
// Parallel port cable handshake: FIFO, ECP and EPP 1.9/1.7 host side.
// Assumes cable inputs already synchronous to clock; reset held while clock stable.
`timescale 1ns/1ps

// Summary of operation
// R1 - FIFO mode paces on Busy, ignores nACK
// R2 - FIFO mode bytes arrive by DMA stream
// R3 - ECP forward idle holds strobe high
// R4 - Peripheral may request reverse any time
// R5 - Strobe falls after Busy seen low
// R6 - Data stable before strobe falls
// R7 - Busy high, strobe rises, Busy low ends
// R8 - ECP reverse idle keeps HostAck low
// R9 - HostAck low, then peripheral drops nACK
// R10 - Peripheral data stable before nACK falls
// R11 - HostAck high, nACK high, HostAck low
// R12 - nWAIT settled after 50 ns quiet
// R13 - nWRITE high outside write cycles
// R14 - EPP 1.9 strobe 60-210 ns after wait
// R15 - Peripheral releases nWAIT after strobe
// R16 - Read releases data before strobe
// R17 - Peripheral drives data only during strobe
// R18 - EPP 1.7 data held 50 ns after strobe
// R19 - Reset held while clock stable
// R20 - Busy qualified after 75 ns stable
// R21 - FIFO mode keeps last byte driven
// R22 - One selected protocol drives the cable
module pph_top
  import pph_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rstn,
  input  wire logic           clk_en,
  input  wire pph_mode_t      mode,
  input  wire logic           ecp_reverse,
  input  wire logic [7:0]     dma_data,
  input  wire logic           dma_valid,
  output logic                dma_ready,
  input  wire pph_epp_cmd_t   epp_cmd,
  input  wire logic           epp_cmd_valid,
  output logic                epp_cmd_ready,
  output logic [7:0]          rx_data,
  output logic                rx_valid,
  output logic                periph_request,
  input  wire pph_cable_in_t  cable_in,
  output pph_cable_out_t      cable_out
);

  typedef enum
  {
    ST_IDLE,
    ST_F_SETUP,
    ST_F_PULSE,
    ST_F_BUSYHI,
    ST_F_HOLD,
    ST_E_WAITBUSY,
    ST_E_STROBE,
    ST_E_RELEASE,
    ST_R_WAITACK,
    ST_R_ACKHI,
    ST_R_ACKLO,
    ST_P_WAITLOW,
    ST_P_CMD,
    ST_P_WAITHI,
    ST_P_HOLD
  } pph_state_t;

  typedef struct packed
  {
    pph_state_t     fsm;
    logic [TMR_W-1:0] tmr;
    pph_cable_out_t co;
    logic           qbusy;
    logic [FLT_W-1:0] busy_cnt;
    logic           qwait_n;
    logic [FLT_W-1:0] wait_cnt;
    logic           qack_n;
    logic [FLT_W-1:0] ack_cnt;
    logic           ecp_rev;
    logic           cmd_read;
    logic           cmd_ready;
    logic [7:0]     rx_data;
    logic           rx_valid;
    logic           preq;
    logic           cmd_addr;
  } pph_top_state_t;

  pph_top_state_t st;
  pph_top_state_t next_st;
  logic [7:0]     q_data;
  logic           q_valid;
  logic           q_ready;
  logic           epp_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Outgoing byte buffer fed by DMA

  pph_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .rstn      (rstn),
    .clk_en    (clk_en),
    .in_data   (dma_data),
    .in_valid  (dma_valid),
    .in_ready  (dma_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  assign epp_mode = (mode == PPH_MODE_EPP19) || (mode == PPH_MODE_EPP17);
  // Byte leaves the buffer when it is put on the cable
  assign q_ready  = clk_en && ((st.fsm == ST_IDLE && q_valid && !epp_mode
                    && (mode == PPH_MODE_FIFO || !st.ecp_rev) && next_st.fsm != ST_IDLE));

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb
  begin
    next_st = st;
    next_st.rx_valid = 1'b0;
    next_st.cmd_ready = 1'b0;
    next_st.preq = !cable_in.fault_n && (mode == PPH_MODE_ECP); // R4

    // Input qualifiers: level accepted after a quiet run
    if (cable_in.busy == st.qbusy)
    begin
      next_st.busy_cnt = '0;
    end
    else if (st.busy_cnt == FLT_W'(BUSY_QUAL_CYC - 1))
    begin
      next_st.qbusy = cable_in.busy; // R20
      next_st.busy_cnt = '0;
    end
    else
    begin
      next_st.busy_cnt = st.busy_cnt + 1'b1;
    end
    if (cable_in.wait_n == st.qwait_n)
    begin
      next_st.wait_cnt = '0;
    end
    else if (st.wait_cnt == FLT_W'(WAIT_QUIET_CYC - 1))
    begin
      next_st.qwait_n = cable_in.wait_n; // R12
      next_st.wait_cnt = '0;
    end
    else
    begin
      next_st.wait_cnt = st.wait_cnt + 1'b1;
    end
    if (cable_in.ack_n == st.qack_n)
    begin
      next_st.ack_cnt = '0;
    end
    else if (st.ack_cnt == FLT_W'(BUSY_QUAL_CYC - 1))
    begin
      next_st.qack_n = cable_in.ack_n;
      next_st.ack_cnt = '0;
    end
    else
    begin
      next_st.ack_cnt = st.ack_cnt + 1'b1;
    end

    if (st.tmr != '0)
    begin
      next_st.tmr = st.tmr - 1'b1;
    end

    case (st.fsm)
      ST_IDLE:
      begin
        next_st.co.strobe_n = 1'b1; // R3
        next_st.co.write_n = 1'b1; // R13
        next_st.co.addr_strobe_n = 1'b1;
        next_st.ecp_rev = (mode == PPH_MODE_ECP) && ecp_reverse;
        if (mode == PPH_MODE_FIFO && q_valid && !st.qbusy) // R1 R2
        begin
          next_st.co.data_out = q_data;
          next_st.co.data_oe = 1'b1;
          next_st.tmr = TMR_W'(FIFO_SETUP_CYC);
          next_st.fsm = ST_F_SETUP;
        end
        else if (mode == PPH_MODE_ECP && !st.ecp_rev && q_valid) // R2
        begin
          next_st.co.data_out = q_data; // R6
          next_st.co.data_oe = 1'b1;
          next_st.co.autofd_n = 1'b1;
          next_st.fsm = ST_E_WAITBUSY;
        end
        else if (mode == PPH_MODE_ECP && st.ecp_rev)
        begin
          next_st.co.data_oe = 1'b0;
          next_st.co.autofd_n = 1'b0; // R9
          next_st.fsm = ST_R_WAITACK;
        end
        else if (epp_mode && epp_cmd_valid && !st.qwait_n)
        begin
          next_st.cmd_read = epp_cmd.is_read;
          next_st.cmd_ready = 1'b1;
          next_st.co.write_n = epp_cmd.is_read;
          next_st.co.data_out = epp_cmd.wdata;
          next_st.co.data_oe = !epp_cmd.is_read; // R16
          next_st.co.addr_strobe_n = 1'b1;
          next_st.tmr = TMR_W'(CMD_DELAY_CYC);
          next_st.fsm = ST_P_CMD;
          next_st.co.autofd_n = 1'b1;
          next_st.cmd_addr = epp_cmd.is_addr;
        end
        else if (mode == PPH_MODE_ECP)
        begin
          next_st.co.autofd_n = 1'b0; // R8
        end
      end
      ST_F_SETUP:
      begin
        if (st.tmr == '0)
        begin
          next_st.co.strobe_n = 1'b0;
          next_st.tmr = TMR_W'(FIFO_PULSE_CYC);
          next_st.fsm = ST_F_PULSE;
        end
      end
      ST_F_PULSE:
      begin
        if (st.tmr == '0)
        begin
          next_st.co.strobe_n = 1'b1;
          next_st.tmr = TMR_W'(FIFO_HOLD_CYC);
          next_st.fsm = ST_F_HOLD;
        end
      end
      ST_F_HOLD:
      begin
        // Data stays driven; next byte only once Busy drops
        if (st.tmr == '0 && !st.qbusy) // R1 R21
        begin
          next_st.tmr = TMR_W'(FIFO_GAP_CYC);
          next_st.fsm = ST_F_BUSYHI;
        end
      end
      ST_F_BUSYHI:
      begin
        if (st.tmr == '0)
        begin
          next_st.fsm = ST_IDLE;
        end
      end
      ST_E_WAITBUSY:
      begin
        if (!st.qbusy) // R5
        begin
          next_st.co.strobe_n = 1'b0;
          next_st.fsm = ST_E_STROBE;
        end
      end
      ST_E_STROBE:
      begin
        if (st.qbusy) // R7
        begin
          next_st.co.strobe_n = 1'b1;
          next_st.fsm = ST_E_RELEASE;
        end
      end
      ST_E_RELEASE:
      begin
        if (!st.qbusy) // R7
        begin
          next_st.fsm = ST_IDLE;
        end
      end
      ST_R_WAITACK:
      begin
        if (!ecp_reverse && st.qack_n)
        begin
          next_st.fsm = ST_IDLE;
        end
        else if (!st.qack_n) // R9
        begin
          next_st.co.autofd_n = 1'b1; // R11
          next_st.rx_data = cable_in.data_in;
          next_st.fsm = ST_R_ACKHI;
        end
      end
      ST_R_ACKHI:
      begin
        if (st.qack_n) // R11
        begin
          next_st.co.autofd_n = 1'b0;
          next_st.rx_valid = 1'b1;
          next_st.fsm = ST_R_WAITACK;
        end
      end
      ST_P_CMD:
      begin
        // Strobe after settled wait low, within the window
        if (st.tmr == '0) // R14 R16
        begin
          if (st.cmd_addr)
          begin
            next_st.co.addr_strobe_n = 1'b0;
          end
          else
          begin
            next_st.co.strobe_n = 1'b0;
          end
          next_st.fsm = ST_P_WAITHI;
        end
      end
      ST_P_WAITHI:
      begin
        if (st.qwait_n) // R15
        begin
          if (st.cmd_read)
          begin
            next_st.rx_data = cable_in.data_in; // R17
            next_st.rx_valid = 1'b1;
          end
          next_st.co.strobe_n = 1'b1;
          next_st.co.addr_strobe_n = 1'b1;
          next_st.tmr = TMR_W'(DATA_HOLD_CYC);
          next_st.fsm = ST_P_HOLD;
        end
      end
      ST_P_HOLD:
      begin
        if (st.tmr == '0) // R18
        begin
          next_st.co.write_n = 1'b1; // R13
          next_st.fsm = ST_IDLE;
        end
      end
      default:
      begin
        next_st.fsm = ST_IDLE;
      end
    endcase

    // Leaving ECP mode during reverse aborts to idle with HostAck high
    if (mode != PPH_MODE_ECP && st.ecp_rev) // R22
    begin
      next_st.ecp_rev = 1'b0;
      next_st.co.autofd_n = 1'b1;
      next_st.fsm = ST_IDLE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      st <= '{fsm: ST_IDLE, tmr: '0,
              co: '{strobe_n: 1'b1, autofd_n: 1'b1, write_n: 1'b1, addr_strobe_n: 1'b1,
                    data_out: DATA_RESET, data_oe: 1'b0},
              qbusy: 1'b0, busy_cnt: '0, qwait_n: 1'b1, wait_cnt: '0,
              qack_n: 1'b1, ack_cnt: '0, ecp_rev: 1'b0, cmd_read: 1'b0,
              cmd_ready: 1'b0, rx_data: DATA_RESET, rx_valid: 1'b0,
              preq: 1'b0, cmd_addr: 1'b0};
    end
    else if (clk_en)
    begin
      st <= next_st;
    end
  end

  assign cable_out      = st.co;
  assign rx_data        = st.rx_data;
  assign rx_valid       = st.rx_valid;
  assign periph_request = st.preq;
  assign epp_cmd_ready  = st.cmd_ready;

endmodule

// ==== sim/pph_top_asserts.sv ====
// Checker for the parallel port handshake top, bound to its ports.
// Assumes one clock domain and the cable filter figures of the package.
`timescale 1ns/1ps
module pph_chk
  import pph_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rstn,
  input  wire pph_mode_t      mode,
  input  wire logic           ecp_reverse,
  input  wire logic           epp_cmd_ready,
  input  wire logic           periph_request,
  input  wire pph_cable_in_t  cable_in,
  input  wire pph_cable_out_t cable_out
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  logic fwd;
  logic rev;
  logic epp;
  logic strb;
  assign fwd  = (mode == PPH_MODE_ECP) && !ecp_reverse;
  assign rev  = (mode == PPH_MODE_ECP) && ecp_reverse;
  assign epp  = (mode == PPH_MODE_EPP19) || (mode == PPH_MODE_EPP17);
  assign strb = !cable_out.strobe_n || !cable_out.addr_strobe_n;

  ////////////////////////////////////////////////////////////////////////////
  write_idle_a : assert property (!epp |-> cable_out.write_n)
    else $error("write line low outside EPP");
  cmd_pulse_a : assert property (epp_cmd_ready |=> !epp_cmd_ready)
    else $error("command ready longer than one cycle");
  strobe_early_a : assert property (epp_cmd_ready |-> !strb [*6])
    else $error("EPP strobe too early");
  strobe_late_a : assert property (epp_cmd_ready |-> ##[6:15] strb)
    else $error("EPP strobe too late");
  read_hiz_a : assert property (epp && strb && cable_out.write_n |-> !cable_out.data_oe)
    else $error("data driven during read strobe");
  epp_hold_a : assert property ((mode == PPH_MODE_EPP17) && !cable_out.write_n && $rose(!strb)
    |-> (cable_out.data_oe && $stable(cable_out.data_out)) [*5])
    else $error("EPP write data not held");
  ecp_start_a : assert property (fwd && $fell(cable_out.strobe_n)
    |-> !$past(cable_in.busy) && !$past(cable_in.busy, 7) && cable_out.data_oe)
    else $error("ECP strobe fell without settled busy low");
  ecp_end_a : assert property (fwd && $rose(cable_out.strobe_n)
    |-> $past(cable_in.busy) && $past(cable_in.busy, 7))
    else $error("ECP strobe rose without settled busy high");
  fifo_start_a : assert property ((mode == PPH_MODE_FIFO) && $fell(cable_out.strobe_n)
    |-> !$past(cable_in.busy) && cable_out.data_oe && $past(cable_out.data_oe, 50))
    else $error("FIFO strobe without setup or busy low");
  fifo_keep_a : assert property ((mode == PPH_MODE_FIFO && cable_out.data_oe) ##1 (mode == PPH_MODE_FIFO)
    |-> cable_out.data_oe)
    else $error("FIFO mode released data lines");
  rev_ack_a : assert property (rev && $rose(cable_out.autofd_n)
    |-> !$past(cable_in.ack_n) && !$past(cable_in.ack_n, 7))
    else $error("host ack rose without settled ack low");
  req_follow_a : assert property ((mode == PPH_MODE_ECP) ##1 (mode == PPH_MODE_ECP)
    |-> periph_request == !$past(cable_in.fault_n))
    else $error("peripheral request not followed");
endmodule

bind pph_top pph_chk chk (
  .clock          (clock),
  .rstn           (rstn),
  .mode           (mode),
  .ecp_reverse    (ecp_reverse),
  .epp_cmd_ready  (epp_cmd_ready),
  .periph_request (periph_request),
  .cable_in       (cable_in),
  .cable_out      (cable_out)
);

// ==== sim/pph_periph.sv ====
// Behavioural peripheral on the parallel cable.
// Assumes clock of the host block; answers after 12 or 31 cycles.
`timescale 1ns/1ps
module pph_periph
  import pph_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           rstn,
  input  wire pph_mode_t      mode,
  input  wire logic           slow,
  input  wire logic           req,
  input  wire pph_cable_out_t cable_out,
  output pph_cable_in_t       cable_in
);
  localparam logic [7:0] RD_VAL = 8'h5A;
  logic [8:0]     got [$];
  logic [7:0]     rev;
  logic [31:0]    sh_b;
  logic [31:0]    sh_a;
  logic [31:0]    sh_w;
  logic           trig_b;
  logic           trig_a;
  logic           trig_w;
  logic           rd;
  pph_cable_out_t prev;

  assign trig_b = (mode == PPH_MODE_FIFO || mode == PPH_MODE_ECP) && !cable_out.strobe_n;
  assign trig_a = (mode == PPH_MODE_ECP) && !cable_out.autofd_n;
  assign trig_w = !cable_out.strobe_n || !cable_out.addr_strobe_n;
  assign rd     = mode[1] && cable_out.write_n && trig_w;

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      sh_b     <= 32'h0;
      sh_a     <= 32'h0;
      sh_w     <= 32'h0;
      rev      <= 8'hA0;
      prev     <= cable_out;
      cable_in <= '{busy: 1'h0, ack_n: 1'h1, fault_n: 1'h1, wait_n: 1'h0, data_in: 8'h00};
    end
    else
    begin
      sh_b             <= {sh_b[30:0], trig_b};
      sh_a             <= {sh_a[30:0], trig_a};
      sh_w             <= {sh_w[30:0], trig_w};
      prev             <= cable_out;
      cable_in.busy    <= slow ? sh_b[29] : sh_b[10];
      cable_in.ack_n   <= !(slow ? sh_a[29] : sh_a[10]);
      cable_in.wait_n  <= slow ? sh_w[29] : sh_w[10];
      cable_in.fault_n <= !req;
      // Released lines toggle so a stale value never passes
      if (trig_a || !cable_in.ack_n)
        cable_in.data_in <= rev;
      else if (rd)
        cable_in.data_in <= RD_VAL;
      else
        cable_in.data_in <= ~cable_in.data_in;
      if (!cable_in.ack_n && !(slow ? sh_a[29] : sh_a[10]))
        rev <= rev + 8'h01;
      if (cable_out.strobe_n && !prev.strobe_n && (!mode[1] || !cable_out.write_n))
        got.push_back({1'h0, cable_out.data_out});
      if (cable_out.addr_strobe_n && !prev.addr_strobe_n && !cable_out.write_n)
        got.push_back({1'h1, cable_out.data_out});
    end
  end
endmodule

// ==== sim/tb_parallel_port_handshake.sv ====
// Self-checking bench for the parallel port handshake block.
// Assumes the peripheral model on the cable and a 100 MHz clock.
`timescale 1ns/1ps
module tb_parallel_port_handshake;
  import pph_pkg::*;
  logic           clock;
  logic           rstn;
  logic           clk_en;
  pph_mode_t      mode;
  logic           ecp_reverse;
  logic [7:0]     dma_data;
  logic           dma_valid;
  logic           dma_ready;
  pph_epp_cmd_t   epp_cmd;
  logic           epp_cmd_valid;
  logic           epp_cmd_ready;
  logic [7:0]     rx_data;
  logic           rx_valid;
  logic           periph_request;
  pph_cable_in_t  cable_in;
  pph_cable_out_t cable_out;
  logic           slow;
  logic           req;
  int             n_mismatch;
  int             compares;

  pph_top dut (.clock(clock), .rstn(rstn), .clk_en(clk_en), .mode(mode), .ecp_reverse(ecp_reverse),
    .dma_data(dma_data), .dma_valid(dma_valid), .dma_ready(dma_ready), .epp_cmd(epp_cmd),
    .epp_cmd_valid(epp_cmd_valid), .epp_cmd_ready(epp_cmd_ready), .rx_data(rx_data), .rx_valid(rx_valid),
    .periph_request(periph_request), .cable_in(cable_in), .cable_out(cable_out));
  pph_periph pm (.clock(clock), .rstn(rstn), .mode(mode), .slow(slow), .req(req),
    .cable_out(cable_out), .cable_in(cable_in));

  always #5 clock = ~clock;

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask

  task automatic timeout();
    n_mismatch++;
    $display("unexpected at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic wait_got(input int n);
    for (int k = 0; k < 30000; k++)
    begin
      @(posedge clock);
      if (pm.got.size() >= n)
        return;
    end
    timeout();
  endtask

  task automatic wait_rx();
    for (int k = 0; k < 3000; k++)
    begin
      @(posedge clock);
      if (rx_valid === 1'h1)
        return;
    end
    timeout();
  endtask

  task automatic push(input logic [7:0] b);
    @(posedge clock);
    dma_data  <= b;
    dma_valid <= 1'h1;
    for (int k = 0; k < 30000; k++)
    begin
      @(posedge clock);
      if (dma_ready === 1'h1)
      begin
        dma_valid <= 1'h0;
        return;
      end
    end
    timeout();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk({cable_out.strobe_n, cable_out.autofd_n, cable_out.write_n, cable_out.addr_strobe_n}, 16'h000F);
    chk({cable_out.data_oe, cable_out.data_out, dma_ready}, 16'h0001);
    $display("test reset done");
  endtask

  task automatic t_fifo();
    pm.got.delete();
    mode <= PPH_MODE_FIFO;
    for (int i = 0; i < 3; i++)
      push(8'h11 * (i + 1));
    wait_got(3);
    for (int i = 0; i < 3; i++)
      chk(pm.got[i], 16'h0011 * (i + 1));
    repeat (300) @(posedge clock);
    chk({cable_out.data_oe, cable_out.data_out}, 16'h0133);
    $display("test fifo done");
  endtask

  task automatic t_fill();
    pm.got.delete();
    slow <= 1'h1;
    mode <= PPH_MODE_EPP19;
    for (int i = 0; i < 8; i++)
      push(8'h40 + 8'(i));
    repeat (2) @(posedge clock);
    chk(dma_ready, 16'h0000);
    mode <= PPH_MODE_ECP;
    wait_got(8);
    for (int i = 0; i < 8; i++)
      chk(pm.got[i], 16'h0040 + 16'(i));
    chk(dma_ready, 16'h0001);
    slow <= 1'h0;
    $display("test fill done");
  endtask

  task automatic t_rev();
    logic [7:0] e;
    e = pm.rev;
    @(posedge clock);
    mode        <= PPH_MODE_ECP;
    ecp_reverse <= 1'h1;
    for (int i = 0; i < 3; i++)
    begin
      wait_rx();
      chk(rx_data, 16'(e + 8'(i)));
    end
    req <= 1'h1;
    repeat (3) @(posedge clock);
    chk(periph_request, 16'h0001);
    req         <= 1'h0;
    ecp_reverse <= 1'h0;
    repeat (3) @(posedge clock);
    chk(periph_request, 16'h0000);
    $display("test reverse done");
  endtask

  task automatic t_epp();
    logic [7:0] wd;
    for (int m = 2; m < 4; m++)
    begin
      mode <= pph_mode_t'(m);
      for (int c = 0; c < 4; c++)
      begin
        pm.got.delete();
        wd = 8'h80 + 8'(c + 4 * m);
        @(posedge clock);
        epp_cmd       <= '{is_read: c[1], is_addr: c[0], wdata: wd};
        epp_cmd_valid <= 1'h1;
        for (int k = 0; k <= 3000 && epp_cmd_ready !== 1'h1; k++)
        begin
          @(posedge clock);
          if (k == 3000)
            timeout();
        end
        epp_cmd_valid <= 1'h0;
        if (c[1])
        begin
          wait_rx();
          chk(rx_data, 16'h005A);
        end
        else
        begin
          wait_got(1);
          chk(pm.got[0], {7'h00, c[0], wd});
        end
      end
    end
    $display("test epp done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock         = 1'h0;
    rstn          = 1'h0;
    clk_en        = 1'h1;
    mode          = PPH_MODE_FIFO;
    ecp_reverse   = 1'h0;
    dma_data      = 8'h00;
    dma_valid     = 1'h0;
    epp_cmd       = '0;
    epp_cmd_valid = 1'h0;
    slow          = 1'h0;
    req           = 1'h0;
    n_mismatch    = 0;
    compares      = 0;
    repeat (10) @(posedge clock);
    t_reset();
    rstn <= 1'h1;
    t_fifo();
    t_fill();
    t_rev();
    t_epp();
    tally_and_finish();
  end
endmodule
